// File: verilog/ufcbg_pkg.sv
// shared constants and types for the uart frame, flow control and baud generator block
package ufcbg_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_LINE_CONFIG = 32'h4000c85c;
  localparam logic [31:0] ADDR_PERIOD_INT = 32'h4000c868;
  localparam logic [31:0] ADDR_PERIOD_FRAC = 32'h4000c86c;
  localparam logic [31:0] ADDR_TX_DATA = 32'h4000c870;
  localparam logic [31:0] ADDR_LINE_STATUS = 32'h4000c874;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int CFG_W = 7;
  localparam int PER_W = 16;
  localparam int ROOM_W = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
  localparam logic [PER_W-1:0] PER_RESET = 16'h0000;
  localparam logic FRAC_RESET = 1'b0;
  localparam logic [7:0] TX_DATA_RESET = 8'h00;

  // line status bit positions
  localparam int STAT_CTS_ASSERTED = 0;
  localparam int STAT_TX_BUSY = 1;
  localparam int STAT_TX_PENDING = 2;
  localparam int STAT_PARITY_ERR = 3;
  localparam int STAT_FRAME_ERR = 4;
  localparam int STAT_RTS_ASSERTED = 5;

  // ----------------------------------------------------------------
  // timing: reference tick derived from pclk by rate accumulation
  // ----------------------------------------------------------------
  localparam logic [7:0] REF_CLK_MHZ = 8'h18;
  localparam logic [7:0] PCLK_MHZ = 8'hc8;
  localparam logic [2:0] LAST_BIT_SEVEN = 3'h6;
  localparam logic [2:0] LAST_BIT_EIGHT = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // field order gives bit 6 down to bit 0 of the line config word
  typedef struct packed {
    logic auto_handshake_en;
    logic handshake_en;
    logic parity_sense_odd;
    logic parity_en;
    logic two_stop_sel;
    logic eight_data_sel;
    logic sw_request_to_send;
  } ufcbg_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
  } ufcbg_rx_char_t;

  typedef enum logic [4:0] {
    SER_IDLE = 5'b00001,
    SER_START = 5'b00010,
    SER_DATA = 5'b00100,
    SER_PARITY = 5'b01000,
    SER_STOP = 5'b10000
  } ufcbg_ser_state_t;

endpackage

// File: verilog/ufcbg_bit_timer.sv
// bit period timer counting reference ticks, 2n+f ticks per bit
`timescale 1ns/100ps
module ufcbg_bit_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic ref_tick,
  input wire logic restart,
  input wire logic half_first,
  // period setting
  input wire logic [15:0] period_integer,
  input wire logic period_half_step,
  // result
  output logic bit_done
);

  logic [16:0] cnt_q, cnt_d;
  logic half_q, half_d;
  logic done_d;
  logic [16:0] full_len;
  logic [16:0] target;

  always_comb begin
    full_len = {period_integer, 1'b0} + {16'h0000, period_half_step};
    // a half period of 2n+f ticks is n ticks, used to centre receive sampling
    target = half_q ? {1'b0, period_integer} : full_len;
    // a zero divisor would stall the line; run at one tick per bit instead
    if (target == 17'h00000) begin
      target = 17'h00001;
    end
    cnt_d = cnt_q;
    half_d = half_q;
    done_d = 1'b0;
    if (restart) begin
      cnt_d = 17'h00000;
      half_d = half_first;
    end else if (ref_tick) begin
      if (cnt_q + 17'h00001 >= target) begin
        cnt_d = 17'h00000;
        done_d = 1'b1;
        half_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 17'h00001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 17'h00000;
      half_q <= 1'b0;
      bit_done <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      half_q <= half_d;
      bit_done <= done_d;
    end
  end

endmodule // ufcbg_bit_timer

// File: verilog/ufcbg_uart.sv
// uart line configuration, rts/cts flow control, baud generation and character framing
`timescale 1ns/100ps

// How it works
// - auto mode: rts high when room one
// - auto mode: rts low when room exceeds one
// - auto control needs auto and flow bits
// - software rts ignored while auto set
// - flow bit switches rts/cts handshake
// - flow off: transmit ignores cts
// - odd bit picks odd, else even
// - parity bit present only when enabled
// - stop select gives one or two stops
// - length bit gives seven or eight bits
// - software rts drives pin in manual mode
// - software rts set drives pin low
// - software rts clear drives pin high
// - bit rate is 24 MHz over 2n+f
// - fraction lengthens bit by one tick
// - cts high with flow blocks new character
module ufcbg_uart (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  output logic txd,
  input wire logic rxd,
  output logic rts_n,
  input wire logic cts_n,
  // receive fifo side
  input wire logic [ufcbg_pkg::ROOM_W-1:0] rx_fifo_room,
  output ufcbg_pkg::ufcbg_rx_char_t rx_char,
  output logic rx_char_valid
);

  // ----------------------------------------------------------------
  // register file and apb
  // ----------------------------------------------------------------
  ufcbg_pkg::ufcbg_cfg_t cfg_q, cfg_d;
  logic [ufcbg_pkg::PER_W-1:0] per_q, per_d;
  logic frac_q, frac_d;
  logic [7:0] tx_buf_q, tx_buf_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic mapped, commit, tx_write;
  logic tx_pending_q, tx_busy;
  logic cts_s1_q, cts_s2_q;
  logic [31:0] status_word;

  always_comb begin
    mapped = (paddr == ufcbg_pkg::ADDR_LINE_CONFIG) || (paddr == ufcbg_pkg::ADDR_PERIOD_INT) ||
             (paddr == ufcbg_pkg::ADDR_PERIOD_FRAC) || (paddr == ufcbg_pkg::ADDR_TX_DATA) ||
             (paddr == ufcbg_pkg::ADDR_LINE_STATUS);
    // the write lands on the edge at which the master sees pready high
    commit = psel && penable && pready && pwrite && mapped;
    tx_write = commit && (paddr == ufcbg_pkg::ADDR_TX_DATA);
    status_word = 32'h00000000;
    status_word[ufcbg_pkg::STAT_CTS_ASSERTED] = ~cts_s2_q;
    status_word[ufcbg_pkg::STAT_TX_BUSY] = tx_busy;
    status_word[ufcbg_pkg::STAT_TX_PENDING] = tx_pending_q;
    status_word[ufcbg_pkg::STAT_PARITY_ERR] = rx_char.parity_err;
    status_word[ufcbg_pkg::STAT_FRAME_ERR] = rx_char.frame_err;
    status_word[ufcbg_pkg::STAT_RTS_ASSERTED] = ~rts_n;
    cfg_d = cfg_q;
    per_d = per_q;
    frac_d = frac_q;
    tx_buf_d = tx_buf_q;
    prdata_d = prdata;
    pslverr_d = pslverr;
    // one wait state: pready rises in the second access cycle
    pready_d = psel && penable && !pready;
    if (pready_d) begin
      pslverr_d = !mapped;
      prdata_d = 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          ufcbg_pkg::ADDR_LINE_CONFIG: prdata_d = {25'h0000000, cfg_q};
          ufcbg_pkg::ADDR_PERIOD_INT: prdata_d = {16'h0000, per_q};
          ufcbg_pkg::ADDR_PERIOD_FRAC: prdata_d = {31'h00000000, frac_q};
          ufcbg_pkg::ADDR_TX_DATA: prdata_d = {24'h000000, tx_buf_q};
          ufcbg_pkg::ADDR_LINE_STATUS: prdata_d = status_word;
          default: prdata_d = 32'h00000000;
        endcase
      end
    end
    if (commit) begin
      unique case (paddr)
        ufcbg_pkg::ADDR_LINE_CONFIG: cfg_d = pwdata[ufcbg_pkg::CFG_W-1:0];
        ufcbg_pkg::ADDR_PERIOD_INT: per_d = pwdata[ufcbg_pkg::PER_W-1:0];
        ufcbg_pkg::ADDR_PERIOD_FRAC: frac_d = pwdata[0];
        // a write while a character still waits is dropped
        ufcbg_pkg::ADDR_TX_DATA: tx_buf_d = tx_pending_q ? tx_buf_q : pwdata[7:0];
        default: tx_buf_d = tx_buf_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= ufcbg_pkg::CFG_RESET;
      per_q <= ufcbg_pkg::PER_RESET;
      frac_q <= ufcbg_pkg::FRAC_RESET;
      tx_buf_q <= ufcbg_pkg::TX_DATA_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      per_q <= per_d;
      frac_q <= frac_d;
      tx_buf_q <= tx_buf_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and request-to-send
  // ----------------------------------------------------------------
  logic rxd_s1_q, rxd_s2_q, rxd_s3_q;
  logic rts_n_d;

  always_comb begin
    rts_n_d = 1'b1;
    // handshake on only when flow set
    if (cfg_q.handshake_en) begin
      if (cfg_q.auto_handshake_en) begin
        rts_n_d = (rx_fifo_room <= 5'h01);
      end else begin
        rts_n_d = ~cfg_q.sw_request_to_send;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n <= 1'b1;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      rxd_s3_q <= 1'b1;
    end else begin
      rts_n <= rts_n_d;
      cts_s1_q <= cts_n;
      cts_s2_q <= cts_s1_q;
      rxd_s1_q <= rxd;
      rxd_s2_q <= rxd_s1_q;
      rxd_s3_q <= rxd_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // reference tick: 24 of every 200 pclk cycles
  // ----------------------------------------------------------------
  logic [7:0] acc_q, acc_d;
  logic ref_tick_q, ref_tick_d, ref_tick_late_q;

  always_comb begin
    if (acc_q + ufcbg_pkg::REF_CLK_MHZ >= ufcbg_pkg::PCLK_MHZ) begin
      acc_d = acc_q + ufcbg_pkg::REF_CLK_MHZ - ufcbg_pkg::PCLK_MHZ;
      ref_tick_d = 1'b1;
    end else begin
      acc_d = acc_q + ufcbg_pkg::REF_CLK_MHZ;
      ref_tick_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 8'h00;
      ref_tick_q <= 1'b0;
      ref_tick_late_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      ref_tick_q <= ref_tick_d;
      ref_tick_late_q <= ref_tick_q;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  ufcbg_pkg::ufcbg_ser_state_t tx_st_q, tx_st_d;
  ufcbg_pkg::ufcbg_cfg_t tx_cfg_q, tx_cfg_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic [2:0] tx_cnt_q, tx_cnt_d;
  logic tx_par_q, tx_par_d, tx_stop2_q, tx_stop2_d;
  logic tx_pending_d, txd_d, tx_restart, tx_done, tx_gate;

  ufcbg_bit_timer u_tx_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ref_tick(ref_tick_q),
    .restart(tx_restart),
    .half_first(1'b0),
    .period_integer(per_q),
    .period_half_step(frac_q),
    .bit_done(tx_done)
  );

  always_comb begin
    tx_busy = (tx_st_q != ufcbg_pkg::SER_IDLE);
    tx_gate = !cfg_q.handshake_en || !cts_s2_q;
    tx_st_d = tx_st_q;
    tx_cfg_d = tx_cfg_q;
    tx_sh_d = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    tx_par_d = tx_par_q;
    tx_stop2_d = tx_stop2_q;
    txd_d = txd;
    tx_restart = 1'b0;
    // a new write wins over nothing: pending only clears on a start
    tx_pending_d = tx_pending_q || tx_write;
    unique case (tx_st_q)
      ufcbg_pkg::SER_IDLE: begin
        // start one cycle after a tick, as every later edge lags its tick, so the start bit is full length
        if (tx_pending_q && tx_gate && ref_tick_late_q) begin
          tx_st_d = ufcbg_pkg::SER_START;
          tx_cfg_d = cfg_q;
          tx_sh_d = tx_buf_q;
          tx_cnt_d = 3'h0;
          tx_par_d = cfg_q.parity_sense_odd;
          tx_stop2_d = 1'b0;
          txd_d = 1'b0;
          tx_restart = 1'b1;
          tx_pending_d = 1'b0;
        end
      end
      ufcbg_pkg::SER_START: begin
        if (tx_done) begin
          tx_st_d = ufcbg_pkg::SER_DATA;
          txd_d = tx_sh_q[0];
          tx_par_d = tx_par_q ^ tx_sh_q[0];
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
        end
      end
      ufcbg_pkg::SER_DATA: begin
        if (tx_done) begin
          if (tx_cnt_q == (tx_cfg_q.eight_data_sel ? ufcbg_pkg::LAST_BIT_EIGHT : ufcbg_pkg::LAST_BIT_SEVEN)) begin
            if (tx_cfg_q.parity_en) begin
              tx_st_d = ufcbg_pkg::SER_PARITY;
              txd_d = tx_par_q;
            end else begin
              tx_st_d = ufcbg_pkg::SER_STOP;
              txd_d = 1'b1;
            end
          end else begin
            tx_cnt_d = tx_cnt_q + 3'h1;
            txd_d = tx_sh_q[0];
            tx_par_d = tx_par_q ^ tx_sh_q[0];
            tx_sh_d = {1'b0, tx_sh_q[7:1]};
          end
        end
      end
      ufcbg_pkg::SER_PARITY: begin
        if (tx_done) begin
          tx_st_d = ufcbg_pkg::SER_STOP;
          txd_d = 1'b1;
        end
      end
      ufcbg_pkg::SER_STOP: begin
        if (tx_done) begin
          if (tx_cfg_q.two_stop_sel && !tx_stop2_q) begin
            tx_stop2_d = 1'b1;
          end else begin
            tx_st_d = ufcbg_pkg::SER_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= ufcbg_pkg::SER_IDLE;
      tx_cfg_q <= ufcbg_pkg::CFG_RESET;
      tx_sh_q <= 8'h00;
      tx_cnt_q <= 3'h0;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
      tx_pending_q <= 1'b0;
      txd <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cfg_q <= tx_cfg_d;
      tx_sh_q <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      tx_par_q <= tx_par_d;
      tx_stop2_q <= tx_stop2_d;
      tx_pending_q <= tx_pending_d;
      txd <= txd_d;
    end
  end

  // ----------------------------------------------------------------
  // receiver: samples at bit centres, checks the first stop bit only
  // ----------------------------------------------------------------
  ufcbg_pkg::ufcbg_ser_state_t rx_st_q, rx_st_d;
  ufcbg_pkg::ufcbg_cfg_t rx_cfg_q, rx_cfg_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic [2:0] rx_cnt_q, rx_cnt_d;
  logic rx_par_q, rx_par_d, rx_perr_q, rx_perr_d;
  logic rx_restart, rx_done, rx_valid_d;
  ufcbg_pkg::ufcbg_rx_char_t rx_char_d;

  ufcbg_bit_timer u_rx_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ref_tick(ref_tick_q),
    .restart(rx_restart),
    .half_first(1'b1),
    .period_integer(per_q),
    .period_half_step(frac_q),
    .bit_done(rx_done)
  );

  always_comb begin
    rx_st_d = rx_st_q;
    rx_cfg_d = rx_cfg_q;
    rx_sh_d = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    rx_par_d = rx_par_q;
    rx_perr_d = rx_perr_q;
    rx_restart = 1'b0;
    rx_valid_d = 1'b0;
    rx_char_d = rx_char;
    unique case (rx_st_q)
      ufcbg_pkg::SER_IDLE: begin
        // a falling edge is needed: a stop bit held low must not look like a new start
        if (!rxd_s2_q && rxd_s3_q) begin
          rx_st_d = ufcbg_pkg::SER_START;
          rx_cfg_d = cfg_q;
          rx_restart = 1'b1;
        end
      end
      ufcbg_pkg::SER_START: begin
        // a start that is gone by mid bit was a glitch
        if (rx_done) begin
          rx_st_d = rxd_s2_q ? ufcbg_pkg::SER_IDLE : ufcbg_pkg::SER_DATA;
          rx_cnt_d = 3'h0;
          rx_sh_d = 8'h00;
          rx_par_d = rx_cfg_q.parity_sense_odd;
          rx_perr_d = 1'b0;
        end
      end
      ufcbg_pkg::SER_DATA: begin
        if (rx_done) begin
          rx_sh_d = {rxd_s2_q, rx_sh_q[7:1]};
          rx_par_d = rx_par_q ^ rxd_s2_q;
          rx_cnt_d = rx_cnt_q + 3'h1;
          if (rx_cnt_q == (rx_cfg_q.eight_data_sel ? ufcbg_pkg::LAST_BIT_EIGHT : ufcbg_pkg::LAST_BIT_SEVEN)) begin
            rx_st_d = rx_cfg_q.parity_en ? ufcbg_pkg::SER_PARITY : ufcbg_pkg::SER_STOP;
          end
        end
      end
      ufcbg_pkg::SER_PARITY: begin
        if (rx_done) begin
          rx_perr_d = rx_par_q ^ rxd_s2_q;
          rx_st_d = ufcbg_pkg::SER_STOP;
        end
      end
      ufcbg_pkg::SER_STOP: begin
        if (rx_done) begin
          rx_st_d = ufcbg_pkg::SER_IDLE;
          rx_valid_d = 1'b1;
          rx_char_d.data = rx_cfg_q.eight_data_sel ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
          rx_char_d.parity_err = rx_perr_q;
          rx_char_d.frame_err = !rxd_s2_q;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= ufcbg_pkg::SER_IDLE;
      rx_cfg_q <= ufcbg_pkg::CFG_RESET;
      rx_sh_q <= 8'h00;
      rx_cnt_q <= 3'h0;
      rx_par_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rx_char <= '0;
      rx_char_valid <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cfg_q <= rx_cfg_d;
      rx_sh_q <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      rx_par_q <= rx_par_d;
      rx_perr_q <= rx_perr_d;
      rx_char <= rx_char_d;
      rx_char_valid <= rx_valid_d;
    end
  end

endmodule // ufcbg_uart

// File: bench/ufcbg_uart_asserts.sv
// concurrent checks on the uart block ports
`timescale 1ns/100ps
module ufcbg_uart_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // flow control and receive side
  input wire logic rts_n,
  input wire logic [ufcbg_pkg::ROOM_W-1:0] rx_fifo_room,
  input wire ufcbg_pkg::ufcbg_rx_char_t rx_char,
  input wire logic rx_char_valid
);
  // ------------------------------------------------
  // shadow of the line config word
  // ------------------------------------------------
  logic [6:0] cfg_q;
  logic [6:0] cfg_d;
  logic mapped;
  assign mapped = paddr inside {ufcbg_pkg::ADDR_LINE_CONFIG, ufcbg_pkg::ADDR_PERIOD_INT,
    ufcbg_pkg::ADDR_PERIOD_FRAC, ufcbg_pkg::ADDR_TX_DATA, ufcbg_pkg::ADDR_LINE_STATUS};
  always_comb begin
    cfg_d = cfg_q;
    if (psel && penable && pready && pwrite && paddr == ufcbg_pkg::ADDR_LINE_CONFIG) begin
      cfg_d = pwdata[6:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 7'h00;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready not after one wait");
  resp_hold_a: assert property (!pready |-> $stable(pslverr) && $stable(prdata))
    else $error("response changed without pready");
  unmapped_err_a: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong for address");
  rts_off_a: assert property ($past(!cfg_q[5]) |-> rts_n) else $error("rts asserted with flow off");
  rts_auto_a: assert property ($past(cfg_q[5] && cfg_q[6]) |-> rts_n == ($past(rx_fifo_room) <= 5'h01))
    else $error("automatic rts wrong for fifo room");
  rts_manual_a: assert property ($past(cfg_q[5] && !cfg_q[6]) |-> rts_n == !$past(cfg_q[0]))
    else $error("software rts not on pin");
  rx_update_a: assert property ($changed(rx_char) |-> rx_char_valid) else $error("rx char changed without valid");
endmodule // ufcbg_uart_asserts

bind ufcbg_uart ufcbg_uart_asserts ufcbg_uart_asserts_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rts_n(rts_n), .rx_fifo_room(rx_fifo_room), .rx_char(rx_char), .rx_char_valid(rx_char_valid));

// File: bench/ufcbg_remote.sv
// remote serial device: decodes txd frames, sends rxd frames, drives clear-to-send
`timescale 1ns/100ps
module ufcbg_remote (
  // serial lines
  input wire logic txd,
  output logic rxd,
  output logic cts_n,
  // bench control
  input wire logic cts_hold,
  input wire logic [16:0] ticks,
  input wire logic [3:0] nbits,
  // decoded frame, lsb first after the start bit
  output logic [11:0] frm,
  output logic frm_seen
);
  real bit_ns;
  integer i;
  always_comb bit_ns = ticks * 1000.0 / 24.0;
  assign cts_n = cts_hold;
  initial begin
    rxd = 1'b1;
    frm = 12'h000;
    frm_seen = 1'b0;
  end
  always begin
    @(negedge txd);
    #(bit_ns / 2.0);
    frm = 12'h000;
    for (i = 0; i < nbits; i++) begin
      #(bit_ns);
      frm[i] = txd;
    end
    frm_seen = 1'b1;
    #1 frm_seen = 1'b0;
  end
  // start low then bits, idle high after
  task automatic send(input logic [11:0] bits, input int n);
    rxd = 1'b0;
    #(bit_ns);
    for (int k = 0; k < n; k++) begin
      rxd = bits[k];
      #(bit_ns);
    end
    rxd = 1'b1;
  endtask
endmodule // ufcbg_remote

// File: bench/ufcbg_uart_test.sv
// self-checking bench for the uart frame, flow control and baud block
`timescale 1ns/100ps
module ufcbg_uart_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, rxd, rts_n, cts_n, cts_hold, frm_seen, rx_char_valid;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [4:0] rx_fifo_room;
  ufcbg_pkg::ufcbg_rx_char_t rx_char;
  logic [16:0] ticks;
  logic [3:0] nbits;
  logic [11:0] frm;
  logic [32:0] e_apb;
  logic [32:0] apb_q[$];
  logic [11:0] tx_q[$];
  logic [9:0] rx_q[$];
  integer seed = 32'hb660;
  int n_mismatch = 0, num_checks = 0, n_tx = 0, n_sent = 0, cnt, j;
  logic [6:0] c;
  logic [15:0] f;
  ufcbg_uart ufcbg_uart_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd),
    .rts_n(rts_n), .cts_n(cts_n), .rx_fifo_room(rx_fifo_room), .rx_char(rx_char), .rx_char_valid(rx_char_valid));
  ufcbg_remote ufcbg_remote_i (.txd(txd), .rxd(rxd), .cts_n(cts_n), .cts_hold(cts_hold), .ticks(ticks),
    .nbits(nbits), .frm(frm), .frm_seen(frm_seen));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic cmp(input string what, input logic [32:0] exp, input logic [32:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // exp holds {pslverr, prdata}; writes compare pslverr only
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [32:0] exp);
    apb_q.push_back(exp);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // returns {bit count, bits lsb first}
  function automatic logic [15:0] frame(input logic [6:0] cf, input logic [7:0] d);
    logic [11:0] b;
    int n;
    b = cf[1] ? {4'h0, d} : {5'h00, d[6:0]};
    n = cf[1] ? 8 : 7;
    if (cf[3]) begin
      b[n] = (cf[1] ? ^d : ^d[6:0]) ^ cf[4];
      n++;
    end
    b[n] = 1'b1;
    b[n+1] = cf[2];
    n = n + 1 + cf[2];
    return {4'(n), b};
  endfunction
  task automatic tx_char(input logic [6:0] cf, input logic [7:0] d);
    f = frame(cf, d);
    nbits = f[15:12];
    tx_q.push_back(f[11:0]);
    n_sent++;
    apb(1'b1, ufcbg_pkg::ADDR_LINE_CONFIG, {25'h0, cf}, 33'h0);
    apb(1'b1, ufcbg_pkg::ADDR_TX_DATA, {24'h0, d}, 33'h0);
  endtask
  task automatic pin(input logic exp);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    cmp("rts_n", {32'h0, exp}, {32'h0, rts_n});
  endtask
  // ------------------------------------------------
  // result watchers
  // ------------------------------------------------
  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e_apb = apb_q.pop_front();
      if (pwrite) begin
        cmp("pslverr", {32'h0, e_apb[32]}, {32'h0, pslverr});
      end else begin
        cmp("apb_read", e_apb, {pslverr, prdata});
      end
    end
    if (rx_char_valid === 1'b1) begin
      cmp("rx_char", {23'h0, rx_q.pop_front()}, {23'h0, rx_char});
    end
  end
  always @(posedge frm_seen) begin
    cmp("tx_frame", {21'h0, tx_q.pop_front()}, {21'h0, frm});
    n_tx++;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    print_verdict();
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    rx_fifo_room = 5'h10;
    cts_hold = 1'b1;
    ticks = 17'h2;
    nbits = 4'h8;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ufcbg_pkg::ADDR_LINE_CONFIG, 32'h0, 33'h0);
    apb(1'b0, ufcbg_pkg::ADDR_PERIOD_INT, 32'h0, 33'h0);
    apb(1'b0, ufcbg_pkg::ADDR_PERIOD_FRAC, 32'h0, 33'h0);
    apb(1'b1, 32'h4000c878, 32'hffffffff, {1'b1, 32'h0});
    apb(1'b0, 32'h4000c878, 32'h0, {1'b1, 32'h0});
    r = $random(seed);
    apb(1'b1, ufcbg_pkg::ADDR_PERIOD_INT, r, 33'h0);
    apb(0, ufcbg_pkg::ADDR_PERIOD_INT, 32'h0, {17'h0, r[15:0]});
    apb(1'b1, ufcbg_pkg::ADDR_PERIOD_FRAC, r, 33'h0);
    apb(0, ufcbg_pkg::ADDR_PERIOD_FRAC, 32'h0, {32'h0, r[0]});
    apb(1'b1, ufcbg_pkg::ADDR_LINE_CONFIG, r, 33'h0);
    apb(0, ufcbg_pkg::ADDR_LINE_CONFIG, 32'h0, {26'h0, r[6:0]});
    $display("test registers done");
    // start bit length for N,F pairs 1/0, 1/1, 2/1
    for (j = 0; j < 3; j++) begin
      ticks = 17'(2 * (1 + j / 2) + (j > 0));
      apb(1'b1, ufcbg_pkg::ADDR_PERIOD_INT, 32'(1 + j / 2), 33'h0);
      apb(1'b1, ufcbg_pkg::ADDR_PERIOD_FRAC, 32'(j > 0), 33'h0);
      tx_char(7'h02, 8'h01);
      @(negedge txd);
      cnt = 0;
      while (txd === 1'b0) begin
        @(posedge pclk);
        cnt++;
      end
      cmp("bit_len", 33'h1, 33'(cnt >= ticks * 25 / 3 - 1 && cnt <= ticks * 25 / 3 + 2));
      wait (n_tx == n_sent);
    end
    $display("test baud done");
    // every data, stop and parity format, flow off with cts high
    for (j = 0; j < 16; j++) begin
      r = $random(seed);
      tx_char({2'b00, 4'(j), 1'b0}, r[7:0]);
      wait (n_tx == n_sent);
    end
    $display("test transmit formats done");
    // receive, with a parity error then a frame error
    for (j = 0; j < 6; j++) begin
      r = $random(seed);
      c = {2'b00, r[12], r[11] | (j == 4), r[10], r[9], 1'b0};
      f = frame(c, r[7:0]);
      if (j == 4) f[c[1] ? 8 : 7] = ~f[c[1] ? 8 : 7];
      if (j == 5) f[(c[1] ? 8 : 7) + c[3]] = 1'b0;
      rx_q.push_back({c[1] ? r[7:0] : {1'b0, r[6:0]}, j == 4, j == 5});
      apb(1'b1, ufcbg_pkg::ADDR_LINE_CONFIG, {25'h0, c}, 33'h0);
      ufcbg_remote_i.send(f[11:0], int'(f[15:12]));
      repeat (60) @(posedge pclk);
    end
    $display("test receive done");
    apb(1'b1, ufcbg_pkg::ADDR_LINE_CONFIG, 32'h21, 33'h0);
    pin(1'b0);
    apb(1'b1, ufcbg_pkg::ADDR_LINE_CONFIG, 32'h20, 33'h0);
    pin(1'b1);
    apb(1'b1, ufcbg_pkg::ADDR_LINE_CONFIG, 32'h41, 33'h0);
    pin(1'b1);
    for (j = 0; j < 10; j++) begin
      apb(1'b1, ufcbg_pkg::ADDR_LINE_CONFIG, {25'h0, 6'h30, j[0]}, 33'h0);
      r = $random(seed);
      @(posedge pclk);
      rx_fifo_room <= (j < 6) ? 5'(j / 2) : r[4:0];
      pin((j < 6) ? (j < 4) : (r[4:0] <= 5'h01));
    end
    $display("test request to send done");
    tx_char(7'h22, 8'h5a);
    repeat (400) @(posedge pclk);
    cmp("tx_held", 33'(n_sent - 1), 33'(n_tx));
    cts_hold <= 1'b0;
    wait (n_tx == n_sent);
    $display("test clear to send done");
    print_verdict();
  end
endmodule // ufcbg_uart_test
